// ---- verilog/dsm_defs.svh ----
`ifndef DSM_DEFS_SVH
`define DSM_DEFS_SVH
// sample word and lane geometry
`define DSM_SW 24
`define DSM_LP_CH 8
`define DSM_DS_CH 4
`define DSM_WORD_W 192
`define DSM_FIFO_DEPTH 32
// nominal rates in hertz
`define DSM_RATE_44K 18'h0AC44
`define DSM_RATE_48K 18'h0BB80
`define DSM_RATE_88K 18'h15888
`define DSM_RATE_96K 18'h17700
// pass-through latency in sample periods
`define DSM_LAT_SS 4'h4
`define DSM_LAT_DS 4'h8
`define DSM_LAT_MAX 8
// channel-status byte 0 field positions
`define DSM_CS_PC 0
`define DSM_CS_AUDIO 1
`define DSM_CS_PRO_EMPH_LO 2
`define DSM_CS_PRO_LOCK 5
`define DSM_CS_PRO_FS_LO 6
`define DSM_CS_CON_COPY 2
`define DSM_CS_CON_EMPH_LO 3
`define DSM_CS_CON_MODE_LO 6
// status reset value and period counter width
`define DSM_CS_RST 8'h00
`define DSM_PER_W 16
`endif

// ---- verilog/dsm_pkg.sv ----
package dsm_pkg;
	// transmit sequencer, gray along idle-first-second-load
	typedef enum logic [1:0] {
		DSM_IDLE = 2'b00,
		DSM_FIRST = 2'b01,
		DSM_SECOND = 2'b11,
		DSM_LOAD = 2'b10
	} dsm_tx_state_t;
endpackage

// ---- verilog/dsm_top.sv ----
// Summary of operation
// - double mode runs internal rate twice base
// - sample words stay 24 bits wide
// - double mode forces lightpipe sample pair multiplexing
// - channel n goes on lanes 2n-1, 2n
// - lightpipe frames stay at base rate
// - status bit 0 selects professional or consumer
// - professional byte: audio, emphasis, locked, frequency
// - consumer byte: audio, copy, emphasis, mode
// - pass-through latency eight samples when doubled
`timescale 1ns/100ps
`default_nettype none
`include "dsm_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo, flop storage
module dsm_fifo #(
	parameter int W = `DSM_WORD_W,
	parameter int D = `DSM_FIFO_DEPTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D]; // storage words
	logic [AW:0] wr_reg; // write pointer with wrap bit
	logic [AW:0] rd_reg; // read pointer with wrap bit
	wire full_w = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire empty_w = (wr_reg == rd_reg);
	wire push_w = i_in_valid && !full_w;
	wire pop_w = i_out_ready && !empty_w;

	assign o_in_ready = !full_w;
	assign o_out_valid = !empty_w;
	assign o_out_data = mem[rd_reg[AW-1:0]];

	// pointers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push_w) wr_reg <= wr_reg + 1'b1;
			if (pop_w) rd_reg <= rd_reg + 1'b1;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge i_core_clk) begin
		if (push_w) mem[wr_reg[AW-1:0]] <= i_in_data;
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dsm_top import dsm_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_rate_doubling_mode,
	input wire logic i_base_48k,
	input wire logic i_lp_wclk,
	input wire logic [`DSM_WORD_W-1:0] i_lp_rx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	input wire logic [`DSM_WORD_W-1:0] i_tx_data,
	output logic [`DSM_WORD_W-1:0] o_lp_tx_data,
	output logic o_lp_tx_sample_pair_multiplexing,
	output logic o_tx_underrun,
	output logic [17:0] o_int_rate_hz,
	output logic [17:0] o_lp_frame_rate_hz,
	output logic o_sample_tick,
	output logic o_rx_valid,
	output logic [`DSM_WORD_W-1:0] o_rx_data,
	output logic [`DSM_WORD_W-1:0] o_thru_data,
	input wire logic i_cs_pro,
	input wire logic i_cs_nonaudio,
	input wire logic [2:0] i_cs_emph,
	input wire logic i_cs_locked,
	input wire logic [1:0] i_cs_fs,
	input wire logic i_cs_copy,
	input wire logic [1:0] i_cs_mode,
	output logic [7:0] o_cs_tx_byte0,
	input wire logic [7:0] i_cs_rx_byte0,
	output logic o_cs_rx_pro,
	output logic o_cs_rx_nonaudio,
	output logic [2:0] o_cs_rx_emph,
	output logic o_cs_rx_locked,
	output logic [1:0] o_cs_rx_fs,
	output logic o_cs_rx_copy,
	output logic [1:0] o_cs_rx_mode
);
	localparam int SW = `DSM_SW;

	////////////////////////////////////////////////////////////////////////////
	// link frame clock and received frame, two flops from the pin
	logic wclk_s1_reg; // first stage, read only by second
	logic wclk_s2_reg; // stable copy
	logic wclk_d3_reg; // edge finder history
	logic [`DSM_WORD_W-1:0] rxd_s1_reg; // first stage, read only by second
	logic [`DSM_WORD_W-1:0] rxd_s2_reg; // stable copy
	wire frame_edge_w = wclk_s2_reg && !wclk_d3_reg;
	wire ds_w = i_rate_doubling_mode;

	// data is held a whole frame, so a plain two-stage copy is safe
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wclk_s1_reg <= 1'b0;
			wclk_s2_reg <= 1'b0;
			wclk_d3_reg <= 1'b0;
			rxd_s1_reg <= '0;
			rxd_s2_reg <= '0;
		end else begin
			wclk_s1_reg <= i_lp_wclk;
			wclk_s2_reg <= wclk_s1_reg;
			wclk_d3_reg <= wclk_s2_reg;
			rxd_s1_reg <= i_lp_rx_data;
			rxd_s2_reg <= rxd_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame period measure; the midpoint gives the second internal tick
	logic [`DSM_PER_W-1:0] per_cnt_reg; // cycles since last frame
	logic [`DSM_PER_W-1:0] per_reg; // last frame length
	wire mid_w = ds_w && (per_reg != '0) && (per_cnt_reg == (per_reg >> 1));
	wire tick_w = frame_edge_w || mid_w;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			per_cnt_reg <= '0;
			per_reg <= '0;
		end else if (frame_edge_w) begin
			per_cnt_reg <= '0;
			per_reg <= per_cnt_reg + 1'b1;
		end else begin
			per_cnt_reg <= per_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// rates and mode flag
	wire [17:0] base_rate_w = i_base_48k ? `DSM_RATE_48K : `DSM_RATE_44K;
	wire [17:0] dbl_rate_w = i_base_48k ? `DSM_RATE_96K : `DSM_RATE_88K;

	// the lightpipe frame rate never follows the doubled rate
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_int_rate_hz <= `DSM_RATE_44K;
			o_lp_frame_rate_hz <= `DSM_RATE_44K;
			o_lp_tx_sample_pair_multiplexing <= 1'b0;
			o_sample_tick <= 1'b0;
		end else begin
			o_int_rate_hz <= ds_w ? dbl_rate_w : base_rate_w;
			o_lp_frame_rate_hz <= base_rate_w;
			o_lp_tx_sample_pair_multiplexing <= ds_w;
			o_sample_tick <= tick_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lane split and merge: lane 2n carries first, 2n+1 second (zero based)
	wire [`DSM_WORD_W-1:0] rx_a_w; // first samples of a frame
	wire [`DSM_WORD_W-1:0] rx_b_w; // second samples of a frame
	wire [`DSM_WORD_W-1:0] tx_mux_w; // interleaved outgoing frame
	logic [`DSM_WORD_W-1:0] a_reg; // first popped word
	logic [`DSM_WORD_W-1:0] b_reg; // second popped word
	genvar gi;
	generate
		for (gi = 0; gi < `DSM_DS_CH; gi++) begin : g_lane
			assign rx_a_w[gi*SW +: SW] = rxd_s2_reg[(2*gi)*SW +: SW];
			assign rx_b_w[gi*SW +: SW] = rxd_s2_reg[(2*gi+1)*SW +: SW];
			assign tx_mux_w[(2*gi)*SW +: SW] = a_reg[gi*SW +: SW];
			assign tx_mux_w[(2*gi+1)*SW +: SW] = b_reg[gi*SW +: SW];
		end
		// upper half of the high-rate words is unused when doubled
		assign rx_a_w[`DSM_WORD_W-1:`DSM_DS_CH*SW] = '0;
		assign rx_b_w[`DSM_WORD_W-1:`DSM_DS_CH*SW] = '0;
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// receive rebuild, one word per internal tick
	logic [`DSM_WORD_W-1:0] rx_b_reg; // second sample waiting for midpoint

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rx_valid <= 1'b0;
			o_rx_data <= '0;
			rx_b_reg <= '0;
		end else begin
			o_rx_valid <= tick_w;
			if (frame_edge_w) begin
				o_rx_data <= ds_w ? rx_a_w : rxd_s2_reg;
				rx_b_reg <= rx_b_w;
			end else if (mid_w) begin
				o_rx_data <= rx_b_reg;
			end
		end
	end

	rx_order_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		frame_edge_w && ds_w |=> o_rx_data[23:0] == $past(rxd_s2_reg[23:0])
		&& rx_b_reg[23:0] == $past(rxd_s2_reg[47:24]))
		else $error("receive pair order wrong");

	////////////////////////////////////////////////////////////////////////////
	// pass-through delay line, tapped by mode
	logic [`DSM_WORD_W-1:0] thru_reg [`DSM_LAT_MAX]; // sample history
	wire [3:0] lat_w = ds_w ? `DSM_LAT_DS : `DSM_LAT_SS;
	wire [2:0] tap_w = 3'(lat_w - 4'h1);

	assign o_thru_data = thru_reg[tap_w];

	// shifts once per internal sample, so delay counts samples not cycles
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < `DSM_LAT_MAX; i++) thru_reg[i] <= '0;
		end else if (o_rx_valid) begin
			thru_reg[0] <= o_rx_data;
			for (int i = 1; i < `DSM_LAT_MAX; i++) thru_reg[i] <= thru_reg[i-1];
		end
	end

	// checks the shift and the tap together: the cycle after a shift the output is the old seventh stage
	thru_tap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		ds_w && o_rx_valid ##1 ds_w |-> o_thru_data == $past(thru_reg[6]))
		else $error("pass-through tap not eight samples");

	////////////////////////////////////////////////////////////////////////////
	// transmit path: fifo then per-frame sequencer
	dsm_tx_state_t state_reg; // sequencer state
	dsm_tx_state_t state_next; // next state
	logic fifo_valid; // word available
	logic [`DSM_WORD_W-1:0] fifo_data; // head word, 24-bit lanes
	wire pop_w = (state_reg == DSM_FIRST) || (state_reg == DSM_SECOND);
	wire [`DSM_WORD_W-1:0] head_w = fifo_valid ? fifo_data : '0;

	dsm_fifo #(
		.W(`DSM_WORD_W),
		.D(`DSM_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_in_valid(i_tx_valid),
		.o_in_ready(o_tx_ready),
		.i_in_data(i_tx_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(pop_w),
		.o_out_data(fifo_data)
	);

	// next state: two pops per frame when doubled, one otherwise
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DSM_IDLE: if (frame_edge_w) state_next = DSM_FIRST;
			DSM_FIRST: state_next = ds_w ? DSM_SECOND : DSM_LOAD;
			DSM_SECOND: state_next = DSM_LOAD;
			DSM_LOAD: state_next = DSM_IDLE;
			default: state_next = DSM_IDLE;
		endcase
	end

	// an empty fifo sends silence and flags the underrun
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= DSM_IDLE;
			a_reg <= '0;
			b_reg <= '0;
			o_lp_tx_data <= '0;
			o_tx_underrun <= 1'b0;
		end else begin
			state_reg <= state_next;
			o_tx_underrun <= pop_w && !fifo_valid;
			if (state_reg == DSM_FIRST) a_reg <= head_w;
			if (state_reg == DSM_SECOND) b_reg <= head_w;
			if (state_reg == DSM_LOAD) o_lp_tx_data <= ds_w ? tx_mux_w : a_reg;
		end
	end

	tx_pair_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		state_reg == DSM_LOAD && ds_w |=> o_lp_tx_data[23:0] == $past(a_reg[23:0])
		&& o_lp_tx_data[47:24] == $past(b_reg[23:0]))
		else $error("lightpipe pair placement wrong");

	tx_per_frame_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		!$stable(o_lp_tx_data) |-> $past(state_reg) == DSM_LOAD)
		else $error("lightpipe frame changed outside load");

	rate_double_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		ds_w && i_base_48k |=> o_int_rate_hz == `DSM_RATE_96K && o_lp_frame_rate_hz == `DSM_RATE_48K)
		else $error("doubled rate wrong");

	smux_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		$rose(ds_w) |=> o_lp_tx_sample_pair_multiplexing)
		else $error("multiplexing not forced by double mode");

	////////////////////////////////////////////////////////////////////////////
	// channel-status byte 0 format and decode
	wire [7:0] cs_pro_w = {i_cs_fs, i_cs_locked, i_cs_emph, i_cs_nonaudio, 1'b1};
	wire [7:0] cs_con_w = {i_cs_mode, i_cs_emph, i_cs_copy, i_cs_nonaudio, 1'b0};
	wire rx_pro_w = i_cs_rx_byte0[`DSM_CS_PC];

	// fields of the other layout read zero so nothing is misjudged
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_cs_tx_byte0 <= `DSM_CS_RST;
			o_cs_rx_pro <= 1'b0;
			o_cs_rx_nonaudio <= 1'b0;
			o_cs_rx_emph <= 3'h0;
			o_cs_rx_locked <= 1'b0;
			o_cs_rx_fs <= 2'h0;
			o_cs_rx_copy <= 1'b0;
			o_cs_rx_mode <= 2'h0;
		end else begin
			o_cs_tx_byte0 <= i_cs_pro ? cs_pro_w : cs_con_w;
			o_cs_rx_pro <= rx_pro_w;
			o_cs_rx_nonaudio <= i_cs_rx_byte0[`DSM_CS_AUDIO];
			o_cs_rx_emph <= rx_pro_w ? i_cs_rx_byte0[`DSM_CS_PRO_EMPH_LO +: 3]
				: i_cs_rx_byte0[`DSM_CS_CON_EMPH_LO +: 3];
			o_cs_rx_locked <= rx_pro_w && i_cs_rx_byte0[`DSM_CS_PRO_LOCK];
			o_cs_rx_fs <= rx_pro_w ? i_cs_rx_byte0[`DSM_CS_PRO_FS_LO +: 2] : 2'h0;
			o_cs_rx_copy <= !rx_pro_w && i_cs_rx_byte0[`DSM_CS_CON_COPY];
			o_cs_rx_mode <= rx_pro_w ? 2'h0 : i_cs_rx_byte0[`DSM_CS_CON_MODE_LO +: 2];
		end
	end

	cs_pro_fmt_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		i_cs_pro |=> o_cs_tx_byte0[0] && o_cs_tx_byte0[7:6] == $past(i_cs_fs)
		&& o_cs_tx_byte0[5] == $past(i_cs_locked))
		else $error("professional byte layout wrong");

	cs_con_fmt_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		!i_cs_pro |=> !o_cs_tx_byte0[0] && o_cs_tx_byte0[2] == $past(i_cs_copy)
		&& o_cs_tx_byte0[5:3] == $past(i_cs_emph))
		else $error("consumer byte layout wrong");

	cs_decode_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		!i_cs_rx_byte0[0] |=> !o_cs_rx_pro && !o_cs_rx_locked
		&& o_cs_rx_copy == $past(i_cs_rx_byte0[2]))
		else $error("consumer decode wrong");
endmodule

`default_nettype wire

// ---- verification/dsm_lp_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// far-end lightpipe source: base-rate frame clock and one frame word
module dsm_lp_src (
	input wire logic i_run,
	input wire logic [191:0] i_frame,
	output logic o_wclk,
	output logic [191:0] o_lp_data
);
	// clock stands low while stopped, which also stalls the tx drain
	initial begin
		o_wclk = 1'h0;
		o_lp_data = '0;
		#37;
		forever begin
			if (i_run) begin
				// new word ahead of the rise, so it is settled when the edge is sampled
				o_lp_data = i_frame;
				#100 o_wclk = 1'h1;
				#400 o_wclk = 1'h0;
				#300;
			end else begin
				#100;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/double_speed_smux_and_chstat_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dsm_defs.svh"
module double_speed_smux_and_chstat_tb;
	localparam int W = `DSM_WORD_W;
	logic clk, rst_b, mode, b48, tx_valid, run, wclk, tx_ready, mux, und, tick;
	logic [W-1:0] tx_data, frame, lp_rx, lp_tx, rx_data, thru, a, b, rx_exp;
	logic [17:0] int_rate, fr_rate;
	logic cs_pro, cs_na, cs_lk, cs_cp, rx_valid;
	logic [2:0] cs_em;
	logic [1:0] cs_fs, cs_md;
	logic [7:0] cs_tx, cs_rx;
	logic [10:0] dec; // decoded status fields packed
	int fails, checked, nval, k, nund, ntick, nt0;
	bit rx_chk;
	time t_rise;

	dsm_lp_src far (.i_run(run), .i_frame(frame), .o_wclk(wclk), .o_lp_data(lp_rx));
	dsm_top dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_rate_doubling_mode(mode),
		.i_base_48k(b48), .i_lp_wclk(wclk), .i_lp_rx_data(lp_rx), .i_tx_valid(tx_valid),
		.o_tx_ready(tx_ready), .i_tx_data(tx_data), .o_lp_tx_data(lp_tx),
		.o_lp_tx_sample_pair_multiplexing(mux), .o_tx_underrun(und), .o_int_rate_hz(int_rate),
		.o_lp_frame_rate_hz(fr_rate), .o_sample_tick(tick), .o_rx_valid(rx_valid),
		.o_rx_data(rx_data), .o_thru_data(thru), .i_cs_pro(cs_pro), .i_cs_nonaudio(cs_na),
		.i_cs_emph(cs_em), .i_cs_locked(cs_lk), .i_cs_fs(cs_fs), .i_cs_copy(cs_cp),
		.i_cs_mode(cs_md), .o_cs_tx_byte0(cs_tx), .i_cs_rx_byte0(cs_rx),
		.o_cs_rx_pro(dec[10]), .o_cs_rx_nonaudio(dec[9]), .o_cs_rx_emph(dec[8:6]),
		.o_cs_rx_locked(dec[5]), .o_cs_rx_fs(dec[4:3]), .o_cs_rx_copy(dec[2]),
		.o_cs_rx_mode(dec[1:0]));

	////////////////////////////////////////////////////////////////////////////////
	// expected rate for {doubling, base48}
	function automatic logic [17:0] rate(int i);
		rate = i[1] ? (i[0] ? `DSM_RATE_96K : `DSM_RATE_88K) : (i[0] ? `DSM_RATE_48K : `DSM_RATE_44K);
	endfunction
	// pair a then b onto odd and even lanes
	function automatic logic [W-1:0] ilv(logic [W-1:0] x, logic [W-1:0] y);
		ilv = '0;
		for (int n = 0; n < 4; n++) begin
			ilv[48*n+:24] = x[24*n+:24];
			ilv[48*n+24+:24] = y[24*n+:24];
		end
	endfunction
	// one sample of a received frame: odd lanes first, even lanes second
	function automatic logic [W-1:0] half(logic [W-1:0] f, bit sec);
		half = '0;
		for (int n = 0; n < 4; n++) half[24*n+:24] = f[48*n+24*sec+:24];
	endfunction
	function automatic logic [7:0] enc();
		enc = cs_pro ? {cs_fs, cs_lk, cs_em, cs_na, 1'h1} : {cs_md, cs_em, cs_cp, cs_na, 1'h0};
	endfunction
	// fields outside the flagged layout read zero
	function automatic logic [10:0] decx(logic [7:0] v);
		decx = v[0] ? {v[0], v[1], v[4:2], v[5], v[7:6], 3'h0} : {v[0], v[1], v[5:3], 3'h0, v[2], v[7:6]};
	endfunction
	task automatic cmp(logic [W-1:0] got, logic [W-1:0] exp, string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// receive sample count versus through-path arrival of a fresh frame
	task automatic thru_lat(int lat);
		logic [W-1:0] e;
		int n0;
		frame = {6{$urandom}};
		e = mode ? half(frame, 0) : frame;
		k = 0;
		do begin @(negedge clk); k++; end while ((mode ? W'(rx_data[95:0]) : rx_data) !== e && k < 300);
		n0 = nval;
		do begin @(negedge clk); k++; end while ((mode ? W'(thru[95:0]) : thru) !== e && k < 600);
		cmp(nval - n0, lat, "thru latency");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// the frame phase tells the first sample from the midpoint one; the frame is kept as it stood at the rise
	always @(posedge wclk) begin
		t_rise = $time;
		rx_exp = lp_rx;
	end
	// pulse counters: receive samples, underruns and internal ticks
	always @(posedge clk) begin
		if (rx_valid === 1'h1) nval <= nval + 1;
		if (und === 1'h1) nund <= nund + 1;
		if (tick === 1'h1) ntick <= ntick + 1;
	end
	always @(negedge clk) begin
		if (rx_chk && rx_valid === 1'h1) begin
			if (mode)
				cmp(W'(rx_data[95:0]), half(rx_exp, ($time - t_rise) > 550), "rx pair");
			else
				cmp(rx_data, rx_exp, "rx frame");
		end
	end
	// watchdog, well past the expected run of several hundred cycles
	initial begin
		#800000;
		fails++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b, mode, b48, tx_valid, run, rx_chk, cs_rx} = '0;
		{cs_pro, cs_na, cs_em, cs_lk, cs_fs, cs_cp, cs_md} = '0;
		{tx_data, frame, fails, checked, nval, nund, ntick} = '0;
		void'($urandom(86186));
		repeat (10) @(negedge clk);
		cmp(int_rate, `DSM_RATE_44K, "reset rate");
		repeat (6) @(negedge clk);
		rst_b = 1'h1;
		// every rate setting, frame rate stays at base
		for (int i = 0; i < 4; i++) begin
			{mode, b48} = i[1:0];
			repeat (2) @(negedge clk);
			cmp(int_rate, rate(i), "internal rate");
			cmp(fr_rate, rate(i & 1), "frame rate");
			cmp(mux, mode, "mux flag");
		end
		// status byte both ways, both received layouts forced first
		for (int i = 0; i < 40; i++) begin
			{cs_pro, cs_na, cs_em, cs_lk, cs_fs, cs_cp, cs_md} = 11'($urandom);
			cs_rx = (i == 0) ? 8'hFE : (i == 1) ? 8'h01 : 8'($urandom);
			repeat (2) @(negedge clk);
			cmp(cs_tx, enc(), "status out");
			cmp(dec, decx(cs_rx), "status in");
		end
		// far side stalled: fill the fifo with pairs until it refuses
		mode = 1'h1;
		a = {6{$urandom}};
		b = {6{$urandom}};
		k = 0;
		tx_valid = 1'h1;
		tx_data = a;
		while (tx_ready === 1'h1 && k < 40) begin
			@(negedge clk);
			k++;
			tx_data = k[0] ? b : a;
		end
		tx_valid = 1'h0;
		cmp(k, `DSM_FIFO_DEPTH, "fifo depth");
		frame = {6{$urandom}};
		run = 1'h1;
		repeat (40) @(negedge clk);
		rx_chk = 1'h1;
		cmp(lp_tx, ilv(a, b), "tx pairs");
		cmp(nund, 0, "no early underrun");
		repeat (120) @(negedge clk);
		// ten frames of eight cycles carry two internal samples each
		nt0 = ntick;
		repeat (80) @(negedge clk);
		cmp(ntick - nt0, 20, "doubled ticks");
		cmp(lp_tx, '0, "drained");
		cmp(nund != 0, 1'h1, "underrun seen");
		thru_lat(8);
		// back to single speed: full frames, shorter path
		rx_chk = 1'h0;
		mode = 1'h0;
		repeat (40) @(negedge clk);
		rx_chk = 1'h1;
		nt0 = ntick;
		repeat (80) @(negedge clk);
		cmp(ntick - nt0, 10, "base ticks");
		thru_lat(4);
		report_and_stop();
	end
endmodule
`default_nettype wire
